// ===== design/hsl_loop_control.sv
// hsl_loop_control: slot repeat and main pass control of the playback sequencer
`timescale 1ns/1ps
`default_nettype none
module hsl_loop_control #(
  parameter int WAIT_UNIT_CYCLES = hsl_pkg::WAIT_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port from the serial control decoder
  input wire logic regWriteEn,
  input wire logic regReadEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  output logic regReadValid,
  // playback control
  input wire logic playLaunch,
  input wire logic trigStop,
  // effect engine
  output logic effectStart,
  output logic [6:0] effectIndex,
  input wire logic effectDone,
  // status
  output logic seqBusy,
  output logic delayActive,
  output logic [hsl_pkg::SLOT_AW-1:0] activeSlot,
  output logic seqDone,
  output logic seqAbort
);
  import hsl_pkg::*;

  localparam int TW = $clog2(WAIT_UNIT_CYCLES + 1);

  generate
    if (WAIT_UNIT_CYCLES < 2) begin : g_bad_unit
      $error("WAIT_UNIT_CYCLES must be at least 2");
    end
  endgenerate

  hsl_mem_if memPort ();

  hsl_slot_memory u_slots (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .port(memPort.mem)
  );

  logic [7:0] repeatLo;
  logic [7:0] repeatHi;
  logic [7:0] mainRepeat;
  hsl_state_type state;
  logic [2:0] slot;
  logic [REPEAT_W-1:0] repLeft;
  logic [PASS_W-1:0] passLeft;
  logic [6:0] delayLeft;
  logic [TW-1:0] tickCnt;
  logic launchPrev;
  logic rdStage;
  logic [7:0] rdAddrHeld;

  // =====================================================================
  // helpers
  function automatic logic [REPEAT_W-1:0] slotRepeat(input logic [2:0] s,
                                                     input logic [7:0] lo,
                                                     input logic [7:0] hi);
    logic [15:0] both;
    both = {hi, lo};
    return both[s*REPEAT_W +: REPEAT_W];
  endfunction

  function automatic logic isSlotAddr(input logic [7:0] a);
    return (a >= ADDR_SLOT_FIRST) && (a <= ADDR_SLOT_LAST);
  endfunction

  // =====================================================================
  // register file
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      repeatLo <= RESET_REPEAT_LO;
      repeatHi <= RESET_REPEAT_HI;
      mainRepeat <= RESET_MAIN_REPEAT;
    end else if (regWriteEn) begin
      if (regAddr == ADDR_REPEAT_LO) begin
        repeatLo <= regWriteData;
      end
      if (regAddr == ADDR_REPEAT_HI) begin
        repeatHi <= regWriteData;
      end
      if (regAddr == ADDR_MAIN_REPEAT) begin
        mainRepeat <= regWriteData;
      end
    end
  end

  logic [7:0] slotOffset;
  assign slotOffset = regAddr - ADDR_SLOT_FIRST;
  assign memPort.wrEn = regWriteEn && isSlotAddr(regAddr);
  assign memPort.wrAddr = slotOffset[2:0];
  assign memPort.wrData = regWriteData;
  assign memPort.hostRdEn = regReadEn && isSlotAddr(regAddr);
  assign memPort.hostRdAddr = slotOffset[2:0];

  // =====================================================================
  // read path: one staging cycle so slot words and flat registers answer alike
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdStage <= 1'b0;
      rdAddrHeld <= 8'h00;
      regReadData <= 8'h00;
      regReadValid <= 1'b0;
    end else begin
      rdStage <= regReadEn;
      regReadValid <= rdStage;
      if (regReadEn) begin
        rdAddrHeld <= regAddr;
      end
      if (rdStage) begin
        if (isSlotAddr(rdAddrHeld)) begin
          regReadData <= memPort.hostRdData;
        end else if (rdAddrHeld == ADDR_REPEAT_LO) begin
          regReadData <= repeatLo;
        end else if (rdAddrHeld == ADDR_REPEAT_HI) begin
          regReadData <= repeatHi;
        end else if (rdAddrHeld == ADDR_MAIN_REPEAT) begin
          regReadData <= mainRepeat;
        end else begin
          regReadData <= 8'h00;
        end
      end
    end
  end

  // =====================================================================
  // decode of the fetched slot word
  logic [7:0] slotWord;
  logic slotIsStop;
  logic slotIsDelay;
  logic unitTick;
  logic effDone;
  logic goReplay;
  logic goNext;
  logic goEnd;
  logic loopAgain;
  logic startReq;
  logic stopReq;

  assign slotWord = memPort.engRdData;
  assign slotIsDelay = slotWord[WAIT_BIT];
  assign slotIsStop = !slotIsDelay && (slotWord[6:0] == 7'h00);
  assign unitTick = (state == HSL_DELAY) && (tickCnt == TW'(WAIT_UNIT_CYCLES - 1));
  // a zero-length delay counts as played at once
  assign effDone = ((state == HSL_PLAY) && effectDone) ||
                   ((state == HSL_DELAY) && unitTick && (delayLeft == 7'h01)) ||
                   ((state == HSL_DECIDE) && slotIsDelay && (slotWord[6:0] == 7'h00));
  assign goReplay = effDone && (repLeft != '0);
  assign goNext = effDone && (repLeft == '0) && (slot != LAST_SLOT);
  assign goEnd = ((state == HSL_DECIDE) && slotIsStop) ||
                 (effDone && (repLeft == '0) && (slot == LAST_SLOT));
  // an empty first slot ends playback even when looping, to avoid spinning
  assign loopAgain = (passLeft != '0) &&
                     !((state == HSL_DECIDE) && slotIsStop && (slot == 3'h0));
  assign startReq = (state == HSL_IDLE) && playLaunch && !launchPrev;
  assign stopReq = (state != HSL_IDLE) && (trigStop || !playLaunch);

  assign memPort.engRdEn = (state == HSL_FETCH);
  assign memPort.engRdAddr = slot;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      launchPrev <= 1'b0;
    end else begin
      launchPrev <= playLaunch;
    end
  end

  // =====================================================================
  // sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= HSL_IDLE;
      slot <= 3'h0;
      repLeft <= '0;
      passLeft <= '0;
      delayLeft <= 7'h00;
    end else if (stopReq) begin
      state <= HSL_IDLE;
    end else if (goReplay) begin
      repLeft <= repLeft - 1'b1;
      state <= HSL_DECIDE;
    end else if (goNext) begin
      slot <= slot + 3'h1;
      state <= HSL_FETCH;
    end else if (goEnd) begin
      if (loopAgain) begin
        slot <= 3'h0;
        if (passLeft != PASS_INFINITE) begin
          passLeft <= passLeft - 1'b1;
        end
        state <= HSL_FETCH;
      end else begin
        state <= HSL_IDLE;
      end
    end else begin
      unique case (state)
        HSL_IDLE: begin
          if (startReq) begin
            slot <= 3'h0;
            passLeft <= mainRepeat[PASS_W-1:0];
            state <= HSL_FETCH;
          end
        end
        HSL_FETCH: begin
          repLeft <= slotRepeat(slot, repeatLo, repeatHi);
          state <= HSL_DECIDE;
        end
        HSL_DECIDE: begin
          if (slotIsDelay) begin
            delayLeft <= slotWord[6:0];
            state <= HSL_DELAY;
          end else begin
            state <= HSL_PLAY;
          end
        end
        HSL_PLAY: begin
        end
        HSL_DELAY: begin
          if (unitTick) begin
            delayLeft <= delayLeft - 7'h01;
          end
        end
        default: begin
          state <= HSL_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // 10 ms unit divider, restarted on each delay entry
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tickCnt <= '0;
    end else if (state != HSL_DELAY || unitTick) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= tickCnt + 1'b1;
    end
  end

  // =====================================================================
  // effect launch and completion pulses
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      effectStart <= 1'b0;
      effectIndex <= 7'h00;
      seqDone <= 1'b0;
      seqAbort <= 1'b0;
    end else begin
      effectStart <= !stopReq && (state == HSL_DECIDE) && !slotIsDelay && !slotIsStop;
      if ((state == HSL_DECIDE) && !slotIsDelay) begin
        effectIndex <= slotWord[6:0];
      end
      seqDone <= !stopReq && goEnd && !loopAgain;
      seqAbort <= stopReq;
    end
  end

  assign seqBusy = (state != HSL_IDLE);
  assign delayActive = (state == HSL_DELAY);
  assign activeSlot = slot;
endmodule
`default_nettype wire

// ===== design/hsl_pkg.sv
// hsl_pkg: constants and types shared by the sequence loop control files
package hsl_pkg;

  // =====================================================================
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int WAIT_UNIT_MS = 10;
  localparam int WAIT_UNIT_CYCLES = (CLK_HZ / 1000) * WAIT_UNIT_MS;

  // =====================================================================
  // register offsets
  localparam logic [7:0] ADDR_SLOT_FIRST = 8'h0F;
  localparam logic [7:0] ADDR_SLOT_LAST = 8'h16;
  localparam logic [7:0] ADDR_REPEAT_LO = 8'h17;
  localparam logic [7:0] ADDR_REPEAT_HI = 8'h18;
  localparam logic [7:0] ADDR_MAIN_REPEAT = 8'h19;

  // =====================================================================
  // reset values
  localparam logic [7:0] RESET_REPEAT_LO = 8'h00;
  localparam logic [7:0] RESET_REPEAT_HI = 8'h00;
  localparam logic [7:0] RESET_MAIN_REPEAT = 8'h00;
  localparam logic [7:0] RESET_SLOT = 8'h00;

  // =====================================================================
  // field layout
  localparam int SLOT_COUNT = 8;
  localparam int SLOT_AW = 3;
  localparam int WAIT_BIT = 7;
  localparam int REPEAT_W = 2;
  localparam int PASS_W = 3;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [2:0] PASS_INFINITE = 3'h7;

  // =====================================================================
  // sequencer states, gray along idle-fetch-decide-play
  typedef enum logic [2:0] {
    HSL_IDLE = 3'b000,
    HSL_FETCH = 3'b001,
    HSL_DECIDE = 3'b011,
    HSL_PLAY = 3'b010,
    HSL_DELAY = 3'b110
  } hsl_state_type;

endpackage

// ===== design/hsl_mem_if.sv
// hsl_mem_if: ports of the slot memory, one writer and two registered readers
`timescale 1ns/1ps
`default_nettype none
interface hsl_mem_if;
  logic wrEn;
  logic [2:0] wrAddr;
  logic [7:0] wrData;
  logic hostRdEn;
  logic [2:0] hostRdAddr;
  logic [7:0] hostRdData;
  logic engRdEn;
  logic [2:0] engRdAddr;
  logic [7:0] engRdData;

  modport ctrl (
    output wrEn, wrAddr, wrData, hostRdEn, hostRdAddr, engRdEn, engRdAddr,
    input hostRdData, engRdData
  );
  modport mem (
    input wrEn, wrAddr, wrData, hostRdEn, hostRdAddr, engRdEn, engRdAddr,
    output hostRdData, engRdData
  );
endinterface
`default_nettype wire

// ===== design/hsl_slot_memory.sv
// hsl_slot_memory: eight slot words (delay select plus effect index)
`timescale 1ns/1ps
`default_nettype none
module hsl_slot_memory (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // access ports
  hsl_mem_if.mem port
);
  import hsl_pkg::*;

  logic [7:0] mem [SLOT_COUNT];

  // =====================================================================
  // storage, cleared so that slot 1 reads as a stop word after reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        mem[i] <= RESET_SLOT;
      end
    end else if (port.wrEn) begin
      mem[port.wrAddr] <= port.wrData;
    end
  end

  // =====================================================================
  // registered read ports
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      port.hostRdData <= RESET_SLOT;
    end else if (port.hostRdEn) begin
      port.hostRdData <= mem[port.hostRdAddr];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      port.engRdData <= RESET_SLOT;
    end else if (port.engRdEn) begin
      port.engRdData <= mem[port.engRdAddr];
    end
  end
endmodule
`default_nettype wire

// ===== verif/hsl_loop_control_properties.sv
// hsl_loop_control_properties: port assertions for the loop control
`timescale 1ns/1ps
`default_nettype none
module hsl_loop_control_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // watched ports
  input wire logic regReadEn,
  input wire logic regReadValid,
  input wire logic playLaunch,
  input wire logic trigStop,
  input wire logic effectStart,
  input wire logic seqBusy,
  input wire logic delayActive,
  input wire logic [hsl_pkg::SLOT_AW-1:0] activeSlot,
  input wire logic seqDone,
  input wire logic seqAbort
);
  // ====
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_read_answer: assert property (regReadEn |-> ##2 regReadValid)
    else $error("read answer missing");
  a_launch_starts: assert property ($rose(playLaunch) && !seqBusy |=> seqBusy)
    else $error("launch ignored");
  a_first_slot: assert property ($rose(seqBusy) |-> activeSlot == 3'h0)
    else $error("start not at slot one");
  a_trig_stops: assert property (seqBusy && trigStop |=> seqAbort && !seqBusy)
    else $error("trigger did not stop");
  a_launch_drop: assert property (seqBusy && !playLaunch |=> seqAbort)
    else $error("launch clear did not stop");
  a_end_reason: assert property ($fell(seqBusy) && $past(rstn) |-> seqDone || seqAbort)
    else $error("end without reason");
  a_done_clean: assert property (seqDone |-> !seqAbort && !seqBusy)
    else $error("done overlaps abort");
  a_wait_quiet: assert property (delayActive |-> !effectStart)
    else $error("start during wait");
  a_start_pulse: assert property (effectStart |-> seqBusy ##1 !effectStart)
    else $error("start not a pulse");
  c_done: cover property (seqDone);
  c_trig: cover property (seqAbort && $past(trigStop));
  c_wait: cover property (delayActive);
endmodule
bind hsl_loop_control hsl_loop_control_properties u_hsl_loop_control_properties (
  .clk_sys(clk_sys), .rstn(rstn), .regReadEn(regReadEn), .regReadValid(regReadValid),
  .playLaunch(playLaunch), .trigStop(trigStop), .effectStart(effectStart),
  .seqBusy(seqBusy), .delayActive(delayActive), .activeSlot(activeSlot),
  .seqDone(seqDone), .seqAbort(seqAbort));
`default_nettype wire

// ===== verif/hsl_effect_engine_model.sv
// hsl_effect_engine_model: waveform engine answering each start with a done pulse
`timescale 1ns/1ps
`default_nettype none
module hsl_effect_engine_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // engine side
  input wire logic slowMode,
  input wire logic effectStart,
  output logic effectDone
);
  int left;
  // slow mode stretches play time so replays are not always back to back
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      left <= 0;
      effectDone <= 1'b0;
    end else begin
      effectDone <= (left == 1);
      if (effectStart) left <= slowMode ? 7 : 1;
      else if (left != 0) left <= left - 1;
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_hsl_loop_control.sv
// tb_hsl_loop_control: random and corner playback runs of the loop control
`timescale 1ns/1ps
`default_nettype none
module tb_hsl_loop_control;
  import hsl_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic regWriteEn = 1'b0;
  logic regReadEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWriteData = 8'h00;
  logic playLaunch = 1'b0;
  logic trigStop = 1'b0;
  logic slowMode = 1'b0;
  logic effectDone, effectStart, regReadValid, seqBusy, delayActive, seqDone, seqAbort;
  logic [7:0] regReadData;
  logic [6:0] effectIndex;
  logic [SLOT_AW-1:0] activeSlot;
  logic [7:0] sw [8];
  logic [7:0] rl, rh, mainCnt;
  int plays [8];
  int waitCycles = 0;
  localparam int UNIT = 8;
  int miscompares = 0;
  int samples_checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  // short wait unit keeps delay slots cheap to simulate
  hsl_loop_control #(.WAIT_UNIT_CYCLES(UNIT)) u_hsl_loop_control (.clk_sys(clk_sys),
    .rstn(rstn), .regWriteEn(regWriteEn), .regReadEn(regReadEn), .regAddr(regAddr),
    .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
    .playLaunch(playLaunch), .trigStop(trigStop), .effectStart(effectStart),
    .effectIndex(effectIndex), .effectDone(effectDone), .seqBusy(seqBusy),
    .delayActive(delayActive), .activeSlot(activeSlot), .seqDone(seqDone),
    .seqAbort(seqAbort));
  hsl_effect_engine_model u_hsl_effect_engine_model (.clk_sys(clk_sys), .rstn(rstn),
    .slowMode(slowMode), .effectStart(effectStart), .effectDone(effectDone));
  // ====
  // checking helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(inout int t);
    @(posedge clk_sys) #1;
    t++;
    if (t > 20000) begin
      miscompares++;
      end_sim();
    end
  endtask
  function automatic int reps(input int s);
    return (((s < 4 ? rl >> (2 * s) : rh >> (2 * s - 8)) & 3) + 1);
  endfunction
  function automatic int want_plays(input int s);
    for (int k = 0; k < s; k++)
      if (sw[k] == 8'h00) return 0;
    if (sw[s] == 8'h00 || sw[s][7]) return 0;
    return (int'(mainCnt[2:0]) + 1) * reps(s);
  endfunction
  // each delay unit spans UNIT cycles, every replay and every pass waits again
  function automatic int want_wait();
    int w;
    w = 0;
    for (int s = 0; s < 8 && sw[s] != 8'h00; s++)
      if (sw[s][7]) w += int'(sw[s][6:0]) * UNIT * reps(s);
    return w * (int'(mainCnt[2:0]) + 1);
  endfunction
  always @(posedge clk_sys) begin
    #1;
    if (delayActive === 1'b1) waitCycles++;
    if (effectStart === 1'b1) begin
      plays[activeSlot] = plays[activeSlot] + 1;
      chk(effectIndex, sw[activeSlot][6:0]);
    end
  end
  // ====
  // register and playback tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #2;
    regWriteEn = 1'b1;
    regAddr = a;
    regWriteData = d;
    @(posedge clk_sys) #2;
    regWriteEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk_sys) #2;
    regReadEn = 1'b1;
    regAddr = a;
    @(posedge clk_sys) #2;
    regReadEn = 1'b0;
    repeat (1) @(posedge clk_sys);
    #1;
    chk(regReadValid, 1);
    chk(regReadData, want);
  endtask
  // mode 0 corner, 1 random, 2 endless stopped by trigger, 3 endless stopped by launch
  task automatic run(input int mode);
    bit [31:0] n;
    int t;
    t = 0;
    waitCycles = 0;
    for (int s = 0; s < 8; s++) begin
      n = $urandom;
      sw[s] = mode != 1 ? 8'h11 + 8'(s) : n % 6 == 0 ? 8'h00 :
              n % 5 == 0 ? {6'h20, n[9:8]} : {1'b0, n[12:6] | 7'h01};
      plays[s] = 0;
      wr(ADDR_SLOT_FIRST + 8'(s), sw[s]);
    end
    rl = mode == 0 ? 8'hFF : mode == 1 ? 8'($urandom) : 8'h00;
    rh = mode == 0 ? 8'hFF : mode == 1 ? 8'($urandom) : 8'h00;
    mainCnt = mode == 0 ? 8'h06 : mode == 1 ? 8'($urandom % 7) : 8'h07;
    wr(ADDR_REPEAT_LO, rl);
    wr(ADDR_REPEAT_HI, rh);
    wr(ADDR_MAIN_REPEAT, mainCnt);
    slowMode = 1'($urandom);
    @(posedge clk_sys) #2;
    playLaunch = 1'b1;
    if (mode >= 2) begin
      while (plays[0] < 9) tick(t);
      #1;
      if (mode == 2) trigStop = 1'b1;
      else playLaunch = 1'b0;
    end
    while (seqDone !== 1'b1 && seqAbort !== 1'b1) tick(t);
    chk(seqDone, mode < 2);
    chk(seqAbort, mode >= 2);
    #1;
    trigStop = 1'b0;
    playLaunch = 1'b0;
    for (int s = 0; s < 8 && mode < 2; s++) chk(plays[s], want_plays(s));
    if (mode < 2) chk(waitCycles, want_wait());
  endtask
  // ====
  // main sequence
  initial begin
    void'($urandom(31));
    repeat (12) @(posedge clk_sys);
    #2;
    rstn = 1'b1;
    rd(ADDR_REPEAT_LO, 8'h00);
    rd(ADDR_REPEAT_HI, 8'h00);
    rd(ADDR_MAIN_REPEAT, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    wr(ADDR_MAIN_REPEAT, 8'hFF);
    rd(ADDR_MAIN_REPEAT, 8'hFF);
    run(0);
    rd(ADDR_SLOT_LAST, 8'h18);
    repeat (6) run(1);
    run(2);
    run(3);
    rstn = 1'b0;
    repeat (12) @(posedge clk_sys);
    #2;
    rstn = 1'b1;
    rd(ADDR_MAIN_REPEAT, 8'h00);
    rd(ADDR_SLOT_FIRST, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
